// ==== hw/gp_ports.sv ====
// Purpose: two 8-bit bidirectional ports with direction, pull-up and override
// Assumes: rst resets all control state; por_rst additionally clears data latches
// Notes: pin outputs lag register and override changes by one clock
//
// Function
// R1 - port B pin 0 is also external interrupt
// R2 - port B pins 4-7 interrupt on change
// R3 - every port B pin has software pull-up
// R4 - port B pins 6,7 serve serial programming
// R5 - port B direction resets to all ones
// R6 - port B data only cleared at power-on
// R7 - port C is eight-bit bidirectional
// R8 - port C direction set per pin
// R9 - enabled peripheral overrides port C direction
// R10 - software avoids read-modify-write on port C direction
// R11 - peripheral output enable needs its select
// R12 - port C pins 0-2 timer and capture roles
// R13 - port C pins 3-5 serial port roles
// R14 - direction one means input, zero drives latch
// R15 - config bit7 pull-up enable, bit6 edge
// R16 - change compare against last read snapshot
`timescale 1ns/10ps

module gp_ports
  import gp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic [GP_AW-1:0] reg_addr,
  input wire logic [GP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [GP_DW-1:0] reg_rdata,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pullup_en,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  input wire logic [7:0] pc_periph_sel,
  input wire logic [7:0] pc_periph_oe,
  input wire logic [7:0] pc_periph_out,
  output logic [7:0] pc_periph_in,
  input wire logic prog_mode,
  output logic prog_clock,
  output logic prog_data,
  output logic ext_irq_flag,
  output logic change_irq_flag
);

  gp_byte_t port_b_data_reg;
  gp_byte_t port_c_data_reg;
  gp_byte_t port_b_direction_reg;
  gp_byte_t port_c_direction_reg;
  gp_byte_t timer_pullup_config_reg;
  gp_byte_t rdata_reg;
  gp_byte_t rdata_next;
  gp_byte_t pb_out_reg;
  gp_byte_t pb_oe_reg;
  gp_byte_t pb_pullup_reg;
  gp_byte_t pc_out_reg;
  gp_byte_t pc_oe_reg;
  gp_byte_t pc_periph_in_reg;
  gp_byte_t dir_b_eff;
  gp_byte_t prog_mask;
  logic prog_clock_reg;
  logic prog_data_reg;
  logic wr_port_b;
  logic wr_port_c;
  logic wr_dir_b;
  logic wr_dir_c;
  logic wr_config;
  logic wr_status;
  logic pullup_enable_n;
  logic ext_irq_edge_select;

  gp_evt_if evt ();

  // direction bit one floats the driver, zero drives the latch
  function automatic gp_byte_t gp_drive_oe(input gp_byte_t sel, input gp_byte_t poe,
                                           input gp_byte_t dir);
    gp_byte_t oe;
    oe = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      oe[i] = sel[i] ? poe[i] : ~dir[i]; // see R9 see R11 see R14
    end
    return oe;
  endfunction : gp_drive_oe

  // value presented to the pin: peripheral when selected, else the latch
  function automatic gp_byte_t gp_drive_out(input gp_byte_t sel, input gp_byte_t pout,
                                            input gp_byte_t latch);
    gp_byte_t v;
    v = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      v[i] = sel[i] ? pout[i] : latch[i];
    end
    return v;
  endfunction : gp_drive_out

  // write decode
  always_comb
  begin
    wr_port_b = 1'b0;
    wr_port_c = 1'b0;
    wr_dir_b = 1'b0;
    wr_dir_c = 1'b0;
    wr_config = 1'b0;
    wr_status = 1'b0;
    if (!reg_wr)
      wr_port_b = 1'b0;
    else if (reg_addr == GP_ADDR_PORT_B_DATA)
      wr_port_b = 1'b1;
    else if (reg_addr == GP_ADDR_PORT_C_DATA)
      wr_port_c = 1'b1;
    else if (reg_addr == GP_ADDR_PORT_B_DIRECTION)
      wr_dir_b = 1'b1;
    else if (reg_addr == GP_ADDR_PORT_C_DIRECTION)
      wr_dir_c = 1'b1;
    else if (reg_addr == GP_ADDR_TIMER_PULLUP_CONFIG)
      wr_config = 1'b1;
    else if (reg_addr == GP_ADDR_EVT_STATUS)
      wr_status = 1'b1;
  end

  // read mux; data addresses return pin levels, not latches
  always_comb
  begin
    rdata_next = GP_READ_IDLE;
    if (!reg_rd)
      rdata_next = GP_READ_IDLE;
    else if (reg_addr == GP_ADDR_PORT_B_DATA)
      rdata_next = pb_in;
    else if (reg_addr == GP_ADDR_PORT_C_DATA)
      rdata_next = pc_in; // see R7
    else if (reg_addr == GP_ADDR_PORT_B_DIRECTION)
      rdata_next = port_b_direction_reg;
    else if (reg_addr == GP_ADDR_PORT_C_DIRECTION)
      rdata_next = port_c_direction_reg;
    else if (reg_addr == GP_ADDR_TIMER_PULLUP_CONFIG)
      rdata_next = timer_pullup_config_reg;
    else if (reg_addr == GP_ADDR_EVT_STATUS)
    begin
      rdata_next[GP_EVT_EXT_BIT] = evt.ext_flag;
      rdata_next[GP_EVT_CHG_BIT] = evt.chg_flag;
    end
  end

  // read data stands for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= GP_READ_IDLE;
    else
      rdata_reg <= rdata_next;
  end

  // data latches survive ordinary resets; only power-on clears them
  always_ff @(posedge clk or posedge por_rst)
  begin
    if (por_rst)
    begin
      port_b_data_reg <= GP_DATA_POR_VALUE; // see R6
      port_c_data_reg <= GP_DATA_POR_VALUE;
    end
    else
    begin
      if (wr_port_b)
        port_b_data_reg <= reg_wdata; // see R6
      if (wr_port_c)
        port_c_data_reg <= reg_wdata; // see R7
    end
  end

  // direction registers; the override never writes back into them, which is
  // why a read-modify-write still sees the stored bits
  always_ff @(posedge clk or posedge rst or posedge por_rst)
  begin
    if (rst || por_rst)
    begin
      port_b_direction_reg <= GP_DIR_B_RESET; // see R5
      port_c_direction_reg <= GP_DIR_C_RESET;
    end
    else
    begin
      if (wr_dir_b)
        port_b_direction_reg <= reg_wdata;
      if (wr_dir_c)
        port_c_direction_reg <= reg_wdata; // see R8 see R10
    end
  end

  // configuration register: pull-up enable and interrupt edge, rest stored
  always_ff @(posedge clk or posedge rst or posedge por_rst)
  begin
    if (rst || por_rst)
      timer_pullup_config_reg <= GP_CONFIG_RESET;
    else if (wr_config)
      timer_pullup_config_reg <= reg_wdata;
  end

  assign pullup_enable_n = timer_pullup_config_reg[GP_CFG_PULLUP_N_BIT]; // see R15
  assign ext_irq_edge_select = timer_pullup_config_reg[GP_CFG_EDGE_SEL_BIT]; // see R15

  // programming mode turns the clock and data pins into inputs
  assign prog_mask = prog_mode ?
    ((8'h01 << GP_PROG_CLOCK_PIN) | (8'h01 << GP_PROG_DATA_PIN)) : 8'h00; // see R4
  assign dir_b_eff = port_b_direction_reg | prog_mask;

  // pin drivers, all registered so the pads see clean levels
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pb_out_reg <= 8'h00;
      pb_oe_reg <= 8'h00;
      pb_pullup_reg <= 8'h00;
      pc_out_reg <= 8'h00;
      pc_oe_reg <= 8'h00;
    end
    else
    begin
      pb_out_reg <= port_b_data_reg; // see R14
      pb_oe_reg <= gp_drive_oe(8'h00, 8'h00, dir_b_eff); // see R14
      // pull-ups only on pins acting as inputs
      pb_pullup_reg <= pullup_enable_n ? 8'h00 : dir_b_eff; // see R3 see R15
      pc_out_reg <= gp_drive_out(pc_periph_sel, pc_periph_out, port_c_data_reg);
      pc_oe_reg <= gp_drive_oe(pc_periph_sel, pc_periph_oe,
                               port_c_direction_reg); // see R9 see R11
    end
  end

  // pin levels handed to timer, capture and serial peripherals
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pc_periph_in_reg <= 8'h00;
    else
      pc_periph_in_reg <= pc_in; // see R12 see R13
  end

  // serial programming clock and data seen only while in that mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prog_clock_reg <= 1'b0;
      prog_data_reg <= 1'b0;
    end
    else
    begin
      prog_clock_reg <= prog_mode & pb_in[GP_PROG_CLOCK_PIN]; // see R4
      prog_data_reg <= prog_mode & pb_in[GP_PROG_DATA_PIN]; // see R4
    end
  end

  // event detector hookup; a port B read refreshes the change snapshot
  assign evt.pin_b = pb_in;
  assign evt.dir_b = dir_b_eff;
  assign evt.edge_rise = ext_irq_edge_select; // see R1
  assign evt.snap_load = reg_rd && (reg_addr == GP_ADDR_PORT_B_DATA); // see R16
  assign evt.clr_ext = wr_status & reg_wdata[GP_EVT_EXT_BIT];
  assign evt.clr_chg = wr_status & reg_wdata[GP_EVT_CHG_BIT];

  gp_event_det u_event_det (
    .clk(clk),
    .rst(rst),
    .evt(evt)
  );

  assign reg_rdata = rdata_reg;
  assign pb_out = pb_out_reg;
  assign pb_oe = pb_oe_reg;
  assign pb_pullup_en = pb_pullup_reg;
  assign pc_out = pc_out_reg;
  assign pc_oe = pc_oe_reg;
  assign pc_periph_in = pc_periph_in_reg;
  assign prog_clock = prog_clock_reg;
  assign prog_data = prog_data_reg;
  assign ext_irq_flag = evt.ext_flag;
  assign change_irq_flag = evt.chg_flag;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst || por_rst);

  a_dir_b_reset: assert property ($fell(rst) |-> port_b_direction_reg == GP_DIR_B_RESET) // see R5
    else $error("port B direction not all ones after reset");

  a_pb_latch_drive: assert property ( // see R14
    !prog_mode |=> pb_oe == ~$past(port_b_direction_reg) && pb_out == $past(port_b_data_reg))
    else $error("port B driver does not follow direction and latch");

  a_pullup_gate: assert property ( // see R15
    1'b1 |=> pb_pullup_en == ($past(pullup_enable_n) ? 8'h00 : $past(dir_b_eff)))
    else $error("pull-up enable wrong");

  a_prog_inputs: assert property (prog_mode |=> pb_oe[7:6] == 2'b00) // see R4
    else $error("programming pins driven in programming mode");

  a_pc_override: assert property ( // see R11
    pc_periph_sel[2] |=> pc_oe[2] == $past(pc_periph_oe[2])
      && pc_out[2] == $past(pc_periph_out[2]))
    else $error("selected peripheral does not own pin");

  a_pc_direction: assert property ( // see R8
    !pc_periph_sel[6] |=> pc_oe[6] == !$past(port_c_direction_reg[6]))
    else $error("port C direction bit ignored");

  a_read_dir_b: assert property ( // see R5
    reg_rd && reg_addr == GP_ADDR_PORT_B_DIRECTION |=> reg_rdata == $past(port_b_direction_reg)
      ##1 ($past(reg_rd) || reg_rdata == GP_READ_IDLE))
    else $error("register read data wrong or held too long");

  a_data_write: assert property ( // see R7
    reg_wr && reg_addr == GP_ADDR_PORT_C_DATA |=> port_c_data_reg == $past(reg_wdata))
    else $error("port C latch not written");

  a_status_clear: assert property ( // see R16
    evt.clr_chg && dir_b_eff[7:4] == 4'h0 |=> !change_irq_flag)
    else $error("change flag kept with no input pins");

  c_pc_override: cover property (pc_periph_sel[3] && !pc_periph_oe[3] ##1 !pc_oe[3]);
  c_port_b_read: cover property (evt.snap_load ##1 !change_irq_flag);
  c_prog_mode: cover property ($rose(prog_mode) ##2 prog_data);

endmodule : gp_ports

// ==== include/gp_pkg.sv ====
// Purpose: shared constants and types for the dual general-purpose port block
// Assumes: 8-bit register port, one 200 MHz clock
// Notes: offsets are byte addresses on the plain register port

package gp_pkg;

  typedef logic [7:0] gp_byte_t;

  // register port geometry
  localparam int GP_AW = 8;
  localparam int GP_DW = 8;

  // register offsets
  localparam logic [7:0] GP_ADDR_PORT_B_DATA = 8'h06;
  localparam logic [7:0] GP_ADDR_PORT_C_DATA = 8'h07;
  localparam logic [7:0] GP_ADDR_EVT_STATUS = 8'h0B;
  localparam logic [7:0] GP_ADDR_TIMER_PULLUP_CONFIG = 8'h81;
  localparam logic [7:0] GP_ADDR_PORT_B_DIRECTION = 8'h86;
  localparam logic [7:0] GP_ADDR_PORT_C_DIRECTION = 8'h87;

  // reset values
  localparam logic [7:0] GP_DIR_B_RESET = 8'hFF;
  localparam logic [7:0] GP_DIR_C_RESET = 8'hFF;
  localparam logic [7:0] GP_CONFIG_RESET = 8'hFF;
  localparam logic [7:0] GP_DATA_POR_VALUE = 8'h00;
  localparam logic [7:0] GP_READ_IDLE = 8'h00;

  // timer_pullup_config fields
  localparam int GP_CFG_PULLUP_N_BIT = 7;
  localparam int GP_CFG_EDGE_SEL_BIT = 6;

  // event status fields (write one to clear)
  localparam int GP_EVT_EXT_BIT = 1;
  localparam int GP_EVT_CHG_BIT = 0;

  // port B pin roles
  localparam int GP_EXT_IRQ_PIN = 0;
  localparam int GP_CHG_PIN_LO = 4;
  localparam int GP_CHG_PIN_HI = 7;
  localparam int GP_PROG_CLOCK_PIN = 6;
  localparam int GP_PROG_DATA_PIN = 7;

  // port C pin roles
  localparam int GP_TIMER1_OSC_IN_PIN = 0;
  localparam int GP_TIMER1_OSC_OUT_PIN = 1;
  localparam int GP_CAPTURE_COMPARE_PIN = 2;
  localparam int GP_SERIAL_CLOCK_PIN = 3;
  localparam int GP_SERIAL_DATA_IN_PIN = 4;
  localparam int GP_SERIAL_DATA_OUT_PIN = 5;

endpackage : gp_pkg

// ==== include/gp_evt_if.sv ====
// Purpose: carries port B levels and event controls to the event detector
// Assumes: both ends share clk
// Notes: ctrl side is the port top, det side is the detector
`timescale 1ns/10ps

interface gp_evt_if;
  logic [7:0] pin_b;
  logic [7:0] dir_b;
  logic edge_rise;
  logic snap_load;
  logic clr_ext;
  logic clr_chg;
  logic ext_flag;
  logic chg_flag;

  modport ctrl (
    output pin_b,
    output dir_b,
    output edge_rise,
    output snap_load,
    output clr_ext,
    output clr_chg,
    input ext_flag,
    input chg_flag
  );

  modport det (
    input pin_b,
    input dir_b,
    input edge_rise,
    input snap_load,
    input clr_ext,
    input clr_chg,
    output ext_flag,
    output chg_flag
  );
endinterface : gp_evt_if

// ==== hw/gp_event_det.sv ====
// Purpose: external edge interrupt and interrupt-on-change detection for port B
// Assumes: pin levels already synchronous to clk
// Notes: flags are sticky; a set in the clearing cycle wins
`timescale 1ns/10ps

module gp_event_det
  import gp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  gp_evt_if.det evt
);

  logic pin0_prev_reg;
  logic [3:0] snap_reg;
  logic ext_flag_reg;
  logic chg_flag_reg;
  logic ext_hit;
  logic chg_hit;

  // edge on the external interrupt pin, polarity chosen by software
  assign ext_hit = evt.edge_rise ?
    (evt.pin_b[GP_EXT_IRQ_PIN] & ~pin0_prev_reg) :
    (~evt.pin_b[GP_EXT_IRQ_PIN] & pin0_prev_reg); // see R1

  // only pins set as inputs take part in the compare
  assign chg_hit = |((evt.pin_b[GP_CHG_PIN_HI:GP_CHG_PIN_LO] ^ snap_reg)
    & evt.dir_b[GP_CHG_PIN_HI:GP_CHG_PIN_LO]); // see R2 see R16

  // previous level for edge detection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin0_prev_reg <= 1'b0;
    else
      pin0_prev_reg <= evt.pin_b[GP_EXT_IRQ_PIN];
  end

  // levels seen at the last port B read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      snap_reg <= 4'h0;
    else if (evt.snap_load)
      snap_reg <= evt.pin_b[GP_CHG_PIN_HI:GP_CHG_PIN_LO]; // see R16
  end

  // sticky flags; set beats clear so no event is lost
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_flag_reg <= 1'b0;
      chg_flag_reg <= 1'b0;
    end
    else
    begin
      ext_flag_reg <= ext_hit | (ext_flag_reg & ~evt.clr_ext); // see R1
      chg_flag_reg <= chg_hit | (chg_flag_reg & ~evt.clr_chg); // see R2
    end
  end

  assign evt.ext_flag = ext_flag_reg;
  assign evt.chg_flag = chg_flag_reg;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ext_rise_flag: assert property ( // see R1
    evt.edge_rise && $rose(evt.pin_b[GP_EXT_IRQ_PIN]) |=> ext_flag_reg)
    else $error("rising edge on external pin did not set flag");

  a_change_sets_flag: assert property ( // see R16
    (evt.pin_b[7:4] != snap_reg) && (evt.dir_b[7:4] == 4'hF) |=> chg_flag_reg)
    else $error("input mismatch did not set change flag");

  a_flag_holds_idle: assert property ( // see R2
    chg_flag_reg && !evt.clr_chg |=> chg_flag_reg)
    else $error("change flag dropped without a clear");

  c_ext_event: cover property (!ext_flag_reg ##1 ext_flag_reg);
  c_chg_event: cover property (!chg_flag_reg ##1 chg_flag_reg);

endmodule : gp_event_det

// ==== bench/gp_board_model.sv ====
// Purpose: board side of both ports, resolves the pin levels seen by the block
// Assumes: the board releases a line while the port drives it
// Notes: a released line without pull-up toggles every cycle
`timescale 1ns/10ps

module gp_board_model
(
  input wire logic clk,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pb_pullup_en,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  input wire logic [7:0] drv_en,
  input wire logic [7:0] drv_b,
  input wire logic [7:0] drv_c,
  output logic [7:0] pb_in,
  output logic [7:0] pc_in
);
  logic [7:0] float_reg;

  // a floating line must never pass for a stable level
  always_ff @(posedge clk)
  begin
    float_reg <= ~pb_in;
  end

  // port driver first, then board drive, then weak pull-up on released lines
  always_comb
  begin
    pb_in = (pb_oe & pb_out) | (~pb_oe & drv_en & drv_b);
    pb_in = pb_in | (~pb_oe & ~drv_en & (pb_pullup_en | float_reg));
    pc_in = (pc_oe & pc_out) | (~pc_oe & drv_c);
  end
endmodule : gp_board_model

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the dual port block
// Assumes: 200 MHz clock, registers reached over the plain strobe port
// Notes: random traffic from a fixed xorshift seed plus corner cases
`timescale 1ns/10ps

module tb
  import gp_pkg::*;
;
  logic clk, rst, por_rst, reg_wr, reg_rd, prog_mode;
  logic prog_clock, prog_data, ext_irq_flag, change_irq_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pb_in, pb_out, pb_oe, pb_pullup_en;
  logic [7:0] pc_in, pc_out, pc_oe, pc_periph_sel, pc_periph_oe, pc_periph_out;
  logic [7:0] pc_periph_in, drv_en, drv_b, drv_c, rv, dirb, datb, dirc, datc, eoe, eout;
  logic [31:0] seed;
  int err_total, tests_run, cycles;

  gp_ports u_dut (.clk, .rst, .por_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pb_in, .pb_out, .pb_oe, .pb_pullup_en, .pc_in, .pc_out, .pc_oe,
    .pc_periph_sel, .pc_periph_oe, .pc_periph_out, .pc_periph_in, .prog_mode,
    .prog_clock, .prog_data, .ext_irq_flag, .change_irq_flag);

  gp_board_model u_board (.clk, .pb_out, .pb_oe, .pb_pullup_en, .pc_out, .pc_oe,
    .drv_en, .drv_b, .drv_c, .pb_in, .pc_in);

  // free-running clock, 5 ns period
  always #2.5 clk = ~clk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      $display("ERROR %0t timeout", $time);
      end_of_test();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] pin_lvl(input logic [7:0] oe, out, drv);
    return (oe & out) | (~oe & drv);
  endfunction : pin_lvl

  task automatic chk(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // strobes drop on the edge after they were taken, so tasks never collide
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, exp, input string what);
    rd(a, rv);
    chk(rv, exp, what);
  endtask : rdchk

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic pulse_reset(input logic por);
    @(posedge clk);
    rst <= 1'b1;
    por_rst <= por;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
  endtask : pulse_reset

  // read port B first so a persisting mismatch does not re-set the flag
  task automatic clr();
    rd(GP_ADDR_PORT_B_DATA, rv);
    wr(GP_ADDR_EVT_STATUS, 8'h03);
    settle();
  endtask : clr

  task automatic evt(input logic [7:0] pins, input logic [1:0] exp, input string what);
    @(posedge clk);
    drv_b <= pins;
    repeat (3) @(posedge clk);
    #1;
    chk({6'h00, ext_irq_flag, change_irq_flag}, {6'h00, exp}, what);
  endtask : evt

  task automatic end_of_test();
    $display("counts: %0d errors, %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    por_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    prog_mode = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    drv_en = 8'hFF;
    drv_b = 8'h00;
    drv_c = 8'h00;
    pc_periph_sel = 8'h00;
    pc_periph_oe = 8'h00;
    pc_periph_out = 8'h00;
    seed = 32'h00013265;
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    #1 chk(pb_oe, 8'h00, "oe after reset");
    rdchk(GP_ADDR_PORT_B_DIRECTION, 8'hFF, "dir b reset");
    rdchk(GP_ADDR_TIMER_PULLUP_CONFIG, 8'hFF, "config reset");
    rdchk(GP_ADDR_PORT_C_DIRECTION, GP_DIR_C_RESET, "dir c reset");
    wr(8'h10, 8'hA5);
    rdchk(8'h10, GP_READ_IDLE, "unmapped read");
    // random traffic over both ports and the peripheral override
    repeat (16)
    begin
      dirb = rnd();
      datb = rnd();
      dirc = rnd();
      datc = rnd();
      @(posedge clk);
      drv_b <= rnd();
      drv_c <= rnd();
      pc_periph_sel <= rnd();
      pc_periph_oe <= rnd();
      pc_periph_out <= rnd();
      wr(GP_ADDR_PORT_B_DIRECTION, dirb);
      wr(GP_ADDR_PORT_B_DATA, datb);
      wr(GP_ADDR_PORT_C_DIRECTION, dirc);
      wr(GP_ADDR_PORT_C_DATA, datc);
      settle();
      eoe = (pc_periph_sel & pc_periph_oe) | (~pc_periph_sel & ~dirc);
      eout = pin_lvl(pc_periph_sel & pc_periph_oe, pc_periph_out, datc);
      chk(pb_oe, ~dirb, "pb oe");
      chk(pb_out, datb, "pb out");
      chk(pc_oe, eoe, "pc oe");
      chk(pc_out & eoe, eout & eoe, "pc out");
      chk(pc_periph_in, pin_lvl(eoe, eout, drv_c), "periph in");
      rdchk(GP_ADDR_PORT_B_DATA, pin_lvl(~dirb, datb, drv_b), "pb pins");
      rdchk(GP_ADDR_PORT_C_DATA, pin_lvl(eoe, eout, drv_c), "pc pins");
      rdchk(GP_ADDR_PORT_B_DIRECTION, dirb, "dir b");
      rdchk(GP_ADDR_PORT_C_DIRECTION, dirc, "dir c");
    end
    // select gates the peripheral enable; select without enable forces input
    @(posedge clk);
    pc_periph_sel <= 8'h00;
    pc_periph_oe <= 8'hFF;
    wr(GP_ADDR_PORT_C_DIRECTION, 8'hFF);
    settle();
    chk(pc_oe, 8'h00, "oe without select");
    @(posedge clk);
    pc_periph_sel <= 8'hFF;
    pc_periph_oe <= 8'h00;
    wr(GP_ADDR_PORT_C_DIRECTION, 8'h00);
    settle();
    chk(pc_oe, 8'h00, "forced input");
    // pull-ups on released lines, inputs only
    @(posedge clk);
    drv_en <= 8'h00;
    wr(GP_ADDR_TIMER_PULLUP_CONFIG, 8'h7F);
    wr(GP_ADDR_PORT_B_DIRECTION, 8'h0F);
    settle();
    chk(pb_pullup_en, 8'h0F, "pullups on inputs");
    rdchk(GP_ADDR_PORT_B_DATA, (datb & 8'hF0) | 8'h0F, "pulled pins");
    rdchk(GP_ADDR_TIMER_PULLUP_CONFIG, 8'h7F, "config rw");
    wr(GP_ADDR_TIMER_PULLUP_CONFIG, 8'hFF);
    settle();
    chk(pb_pullup_en, 8'h00, "pullups off");
    // external edge and change events
    @(posedge clk);
    drv_en <= 8'hFF;
    drv_b <= 8'h00;
    wr(GP_ADDR_PORT_B_DIRECTION, 8'hFF);
    clr();
    evt(8'h00, 2'b00, "idle flags");
    evt(8'h01, 2'b10, "rising edge");
    rdchk(GP_ADDR_EVT_STATUS, 8'h02, "status ext");
    clr();
    evt(8'h01, 2'b00, "ext cleared");
    wr(GP_ADDR_TIMER_PULLUP_CONFIG, 8'hBF);
    evt(8'h00, 2'b10, "falling edge");
    clr();
    evt(8'h01, 2'b00, "rising ignored");
    evt(8'h21, 2'b01, "change pin5");
    rdchk(GP_ADDR_EVT_STATUS, 8'h01, "status change");
    clr();
    evt(8'h29, 2'b00, "pin3 ignored");
    wr(GP_ADDR_PORT_B_DIRECTION, 8'hEF);
    wr(GP_ADDR_PORT_B_DATA, 8'h00);
    clr();
    wr(GP_ADDR_PORT_B_DATA, 8'h10);
    evt(8'h29, 2'b00, "output pin excluded");
    // serial programming lines; with no input pins a clear must stick
    wr(GP_ADDR_PORT_B_DIRECTION, 8'h00);
    clr();
    chk({6'h00, ext_irq_flag, change_irq_flag}, 8'h00, "no input pins");
    @(posedge clk);
    prog_mode <= 1'b1;
    drv_b <= 8'h80;
    settle();
    chk(pb_oe, 8'h3F, "prog pins input");
    chk({6'h00, prog_clock, prog_data}, 8'h01, "prog data line");
    @(posedge clk);
    drv_b <= 8'h40;
    settle();
    chk({6'h00, prog_clock, prog_data}, 8'h02, "prog clock line");
    @(posedge clk);
    prog_mode <= 1'b0;
    // latch survives a plain reset, cleared only at power-on
    wr(GP_ADDR_PORT_B_DATA, 8'hA5);
    pulse_reset(1'b0);
    rdchk(GP_ADDR_PORT_B_DIRECTION, 8'hFF, "dir b warm reset");
    wr(GP_ADDR_PORT_B_DIRECTION, 8'h00);
    settle();
    chk(pb_out, 8'hA5, "latch kept");
    pulse_reset(1'b1);
    wr(GP_ADDR_PORT_B_DIRECTION, 8'h00);
    settle();
    chk(pb_out, GP_DATA_POR_VALUE, "latch cleared");
    end_of_test();
  end
endmodule : tb
